// *** rtl/spi_cmd_pkg.sv ***
// Shared constants and types for the serial command port and its master
package spi_cmd_pkg;
   // ==========================================
   // Frame layout
   localparam int FRAME_W = 20;
   localparam int MSB = FRAME_W - 1;
   localparam int SEL_HI = 19;
   localparam int SEL_LO = 17;
   localparam int RSP_FIELD_LO = 4;
   localparam int RSP_FIELD_W = 2;
   localparam int COUNT_W = 5;
   localparam logic [COUNT_W-1:0] COUNT_FULL = 5'h14;
   // ==========================================
   // Timing
   localparam int CORE_PERIOD_PS = 4000;
   localparam int FILTER_NS = 20;
   localparam int FILT_CYC = (FILTER_NS * 1000 + CORE_PERIOD_PS - 1) / CORE_PERIOD_PS;
   localparam int FILT_CNT_W = 4;
   localparam int SCK_HALF_CYC = 4;
   localparam int CS_LEAD_CYC = 4;
   localparam int CS_GAP_CYC = 10;
   // ==========================================
   // Reset values
   localparam logic [FRAME_W-1:0] WORD_RESET = 20'h00000;
   localparam logic [2:0] TARGET_RESET = 3'h0;
   // ==========================================
   // Encodings
   typedef enum logic [2:0] {
      TGT_DRIVE_CTRL = 3'h0,
      TGT_CHOPPER = 3'h1,
      TGT_LOAD_ADAPT = 3'h2,
      TGT_LOAD_DETECT = 3'h3,
      TGT_DRIVER_CONF = 3'h4
   } target_t;
   localparam logic [2:0] SEL_CHOPPER = 3'h4;
   localparam logic [2:0] SEL_LOAD_ADAPT = 3'h5;
   localparam logic [2:0] SEL_LOAD_DETECT = 3'h6;
   localparam logic [2:0] SEL_DRIVER_CONF = 3'h7;
   localparam logic [1:0] RSP_POSITION = 2'h0;
   localparam logic [1:0] RSP_LOAD = 2'h1;
   localparam logic [1:0] RSP_LOAD_SCALE = 2'h2;
   typedef enum logic [1:0] {
      M_IDLE = 2'b00,
      M_LEAD = 2'b01,
      M_SHIFT = 2'b11,
      M_GAP = 2'b10
   } master_state_t;
endpackage

// *** rtl/spi_link_if.sv ***
// Four-wire serial link between master and command port
`timescale 1ns/100ps
interface spi_link_if;
   logic sclk;
   logic mosi;
   logic miso;
   logic cs_n;
   modport device (input sclk, input mosi, input cs_n, output miso);
   modport master (output sclk, output mosi, output cs_n, input miso);
endinterface

// *** rtl/spi_cmd_port.sv ***
// Serial command port: shift register on the link clock, command latch on the core clock
//
// Behaviour
// - Transfers only while chip select is low
// - Sample data in on bus clock rise
// - Update data out after bus clock fall
// - Words travel most significant bit first
// - Master gives at least 20 clocks
// - Extra bits reappear on output 20 clocks later
// - Chip select stays low whole transaction
// - Chip select rise latches shift register command
// - Only last 20 bits form the command
// - Bus clock at most half system clock
// - Extra 10% margin on internal oscillator
// - Chip select and disable input filtered against pulses under 20ns; bus clock and data in unfiltered
// - Chained devices behave as one shift register
// - Top bits select target configuration register
// - Response layout from two-bit format select
`timescale 1ns/100ps
module spi_cmd_port
   import spi_cmd_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_b,
   spi_link_if.device link,
   input wire logic driver_disable_input,
   input wire logic [9:0] microstep_pos,
   input wire logic [9:0] load_value,
   input wire logic [4:0] current_scale_act,
   input wire logic [7:0] status_flags,
   output logic [spi_cmd_pkg::FRAME_W-1:0] drive_ctrl_word,
   output logic [spi_cmd_pkg::FRAME_W-1:0] chopper_word,
   output logic [spi_cmd_pkg::FRAME_W-1:0] load_adapt_word,
   output logic [spi_cmd_pkg::FRAME_W-1:0] load_detect_word,
   output logic [spi_cmd_pkg::FRAME_W-1:0] driver_configuration_word,
   output logic command_strobe,
   output spi_cmd_pkg::target_t command_target,
   output logic frame_short,
   output logic driver_disable
);
   import spi_cmd_pkg::*;

   // ==========================================
   // Helpers
   function automatic logic [FILT_CNT_W:0] deglitch(input logic s, input logic f, input logic [FILT_CNT_W-1:0] c);
      if (s == f) begin
         return {f, {FILT_CNT_W{1'b0}}};
      end else if (c == FILT_CNT_W'(FILT_CYC - 1)) begin
         return {s, {FILT_CNT_W{1'b0}}};
      end else begin
         return {f, c + 4'h1};
      end
   endfunction

   function automatic target_t decode_target(input logic [2:0] sel);
      if (sel == SEL_CHOPPER) begin
         return TGT_CHOPPER;
      end else if (sel == SEL_LOAD_ADAPT) begin
         return TGT_LOAD_ADAPT;
      end else if (sel == SEL_LOAD_DETECT) begin
         return TGT_LOAD_DETECT;
      end else if (sel == SEL_DRIVER_CONF) begin
         return TGT_DRIVER_CONF;
      end else begin
         return TGT_DRIVE_CTRL;
      end
   endfunction

   // ==========================================
   // Core clock domain state
   typedef struct packed {
      logic cs_s1;
      logic cs_s2;
      logic cs_filt;
      logic [FILT_CNT_W-1:0] cs_cnt;
      logic en_s1;
      logic en_s2;
      logic en_filt;
      logic [FILT_CNT_W-1:0] en_cnt;
      logic frame_tag;
      logic [FRAME_W-1:0] resp;
      logic [FRAME_W-1:0] w_ctrl;
      logic [FRAME_W-1:0] w_chop;
      logic [FRAME_W-1:0] w_adapt;
      logic [FRAME_W-1:0] w_detect;
      logic [FRAME_W-1:0] w_conf;
      logic strobe;
      target_t target;
      logic short_f;
   } core_state_t;

   // Link rising-edge state
   typedef struct packed {
      logic [FRAME_W-1:0] shift;
      logic [COUNT_W-1:0] count;
      logic seen_tag;
   } rise_state_t;

   // Link falling-edge state
   typedef struct packed {
      logic sdo;
      logic tag;
   } fall_state_t;

   core_state_t core_reg;
   core_state_t core_next;
   rise_state_t rise_reg;
   rise_state_t rise_next;
   fall_state_t fall_reg;
   fall_state_t fall_next;

   // ==========================================
   // Core clock: sync, filter, command latch, response build
   always_comb begin
      logic [FILT_CNT_W:0] cs_d;
      logic [FILT_CNT_W:0] en_d;
      logic [1:0] fmt;
      cs_d = '0;
      en_d = '0;
      fmt = '0;
      core_next = core_reg;
      core_next.strobe = 1'b0;
      core_next.cs_s1 = link.cs_n;
      core_next.cs_s2 = core_reg.cs_s1;
      core_next.en_s1 = driver_disable_input;
      core_next.en_s2 = core_reg.en_s1;
      cs_d = deglitch(core_reg.cs_s2, core_reg.cs_filt, core_reg.cs_cnt);
      en_d = deglitch(core_reg.en_s2, core_reg.en_filt, core_reg.en_cnt);
      core_next.cs_filt = cs_d[FILT_CNT_W];
      core_next.cs_cnt = cs_d[FILT_CNT_W-1:0];
      core_next.en_filt = en_d[FILT_CNT_W];
      core_next.en_cnt = en_d[FILT_CNT_W-1:0];
      // Chip select rise: shift register is still, sclk stopped
      if (cs_d[FILT_CNT_W] && !core_reg.cs_filt) begin
         core_next.frame_tag = ~core_reg.frame_tag;
         core_next.short_f = rise_reg.count < COUNT_FULL;
         if (rise_reg.count >= COUNT_FULL) begin
            core_next.strobe = 1'b1;
            core_next.target = decode_target(rise_reg.shift[SEL_HI:SEL_LO]);
            case (decode_target(rise_reg.shift[SEL_HI:SEL_LO]))
               TGT_CHOPPER: core_next.w_chop = rise_reg.shift;
               TGT_LOAD_ADAPT: core_next.w_adapt = rise_reg.shift;
               TGT_LOAD_DETECT: core_next.w_detect = rise_reg.shift;
               TGT_DRIVER_CONF: core_next.w_conf = rise_reg.shift;
               default: core_next.w_ctrl = rise_reg.shift;
            endcase
         end
      end
      // Response frozen once chip select falls
      fmt = core_reg.w_conf[RSP_FIELD_LO +: RSP_FIELD_W];
      if (core_reg.cs_s2 && core_reg.cs_filt) begin
         case (fmt)
            RSP_POSITION: core_next.resp = {microstep_pos, 2'h0, status_flags};
            RSP_LOAD: core_next.resp = {load_value, 10'h000};
            RSP_LOAD_SCALE: core_next.resp = {load_value[9:5], current_scale_act, 10'h000};
            default: core_next.resp = WORD_RESET;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         core_reg <= '0;
         core_reg.cs_s1 <= 1'b1;
         core_reg.cs_s2 <= 1'b1;
         core_reg.cs_filt <= 1'b1;
         core_reg.en_s1 <= 1'b1;
         core_reg.en_s2 <= 1'b1;
         core_reg.en_filt <= 1'b1;
         core_reg.target <= target_t'(TARGET_RESET);
      end else begin
         core_reg <= core_next;
      end
   end

   // ==========================================
   // Link rising edge: sample and shift
   always_comb begin
      rise_next = rise_reg;
      if (!link.cs_n) begin
         rise_next.seen_tag = core_reg.frame_tag;
         if (rise_reg.seen_tag != core_reg.frame_tag) begin
            rise_next.shift = {core_reg.resp[MSB-1:0], link.mosi};
            rise_next.count = 5'h01;
         end else begin
            rise_next.shift = {rise_reg.shift[MSB-1:0], link.mosi};
            if (rise_reg.count < COUNT_FULL) begin
               rise_next.count = rise_reg.count + 5'h01;
            end
         end
      end
   end

   always_ff @(posedge link.sclk) begin
      rise_reg <= rise_next;
   end

   // ==========================================
   // Link falling edge: drive out, delay of one frame
   always_comb begin
      fall_next = fall_reg;
      if (!link.cs_n) begin
         fall_next.sdo = rise_reg.shift[MSB];
         fall_next.tag = rise_reg.seen_tag;
      end
   end

   always_ff @(negedge link.sclk) begin
      fall_reg <= fall_next;
   end

   // First bit stands from frame start until the first fall
   assign link.miso = (fall_reg.tag != core_reg.frame_tag) ? core_reg.resp[MSB] : fall_reg.sdo;

   // ==========================================
   // Outputs
   assign drive_ctrl_word = core_reg.w_ctrl;
   assign chopper_word = core_reg.w_chop;
   assign load_adapt_word = core_reg.w_adapt;
   assign load_detect_word = core_reg.w_detect;
   assign driver_configuration_word = core_reg.w_conf;
   assign command_strobe = core_reg.strobe;
   assign command_target = core_reg.target;
   assign frame_short = core_reg.short_f;
   assign driver_disable = core_reg.en_filt;
endmodule // spi_cmd_port

// *** rtl/spi_cmd_master.sv ***
// Serial link master: makes the bus clock, shifts a chain of command words
`timescale 1ns/100ps
module spi_cmd_master
   import spi_cmd_pkg::*;
#(
   parameter int CHAIN_LEN = 1,
   parameter int HALF_CYC = spi_cmd_pkg::SCK_HALF_CYC
)
(
   input wire logic core_clk,
   input wire logic rst_b,
   spi_link_if.master link,
   input wire logic start,
   input wire logic [spi_cmd_pkg::FRAME_W*CHAIN_LEN-1:0] tx_word,
   output logic busy,
   output logic done,
   output logic [spi_cmd_pkg::FRAME_W*CHAIN_LEN-1:0] rx_word
);
   import spi_cmd_pkg::*;

   localparam int TOTAL = FRAME_W * CHAIN_LEN;
   localparam int BIT_W = $clog2(TOTAL + 1);

   // ==========================================
   // State
   typedef struct packed {
      master_state_t st;
      logic [7:0] tick;
      logic [BIT_W-1:0] bits;
      logic [TOTAL-1:0] tx;
      logic [TOTAL-1:0] rx;
      logic sclk;
      logic cs_n;
      logic mosi;
      logic mi_s1;
      logic mi_s2;
      logic busy;
      logic done;
   } mst_state_t;

   mst_state_t r_reg;
   mst_state_t r_next;

   always_comb begin
      r_next = r_reg;
      r_next.done = 1'b0;
      r_next.mi_s1 = link.miso;
      r_next.mi_s2 = r_reg.mi_s1;
      r_next.tick = r_reg.tick + 8'h01;
      case (r_reg.st)
         M_IDLE: begin
            r_next.tick = '0;
            if (start) begin
               r_next.st = M_LEAD;
               r_next.busy = 1'b1;
               r_next.cs_n = 1'b0;
               r_next.tx = tx_word;
               r_next.mosi = tx_word[TOTAL-1];
               r_next.bits = '0;
            end
         end
         M_LEAD: begin
            if (r_reg.tick == 8'(CS_LEAD_CYC + HALF_CYC - 1)) begin
               r_next.st = M_SHIFT;
               r_next.tick = '0;
               r_next.sclk = 1'b1;
            end
         end
         M_SHIFT: begin
            if (r_reg.tick == 8'(HALF_CYC - 1)) begin
               r_next.tick = '0;
               r_next.sclk = ~r_reg.sclk;
               if (r_reg.sclk) begin
                  // End of high phase: take the bit, present the next one
                  r_next.rx = {r_reg.rx[TOTAL-2:0], r_reg.mi_s2};
                  r_next.tx = {r_reg.tx[TOTAL-2:0], 1'b0};
                  r_next.mosi = r_reg.tx[TOTAL-2];
                  r_next.bits = r_reg.bits + 1'b1;
                  if (r_reg.bits == BIT_W'(TOTAL - 1)) begin
                     r_next.st = M_GAP;
                     r_next.sclk = 1'b0;
                  end
               end
            end
         end
         M_GAP: begin
            if (r_reg.tick == 8'(HALF_CYC - 1)) begin
               r_next.cs_n = 1'b1;
            end
            if (r_reg.tick == 8'(HALF_CYC + CS_GAP_CYC - 1)) begin
               r_next.st = M_IDLE;
               r_next.busy = 1'b0;
               r_next.done = 1'b1;
            end
         end
         default: r_next.st = M_IDLE;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         r_reg <= '0;
         r_reg.st <= M_IDLE;
         r_reg.cs_n <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   // ==========================================
   // Outputs
   assign link.sclk = r_reg.sclk;
   assign link.cs_n = r_reg.cs_n;
   assign link.mosi = r_reg.mosi;
   assign busy = r_reg.busy;
   assign done = r_reg.done;
   assign rx_word = r_reg.rx;
endmodule // spi_cmd_master

// *** tb/spi_slave_command_port_properties.sv ***
// Link-side assertions for the command port and its master
`timescale 1ns/100ps
module spi_slave_command_port_properties (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic sclk,
   input wire logic mosi,
   input wire logic miso,
   input wire logic cs_n,
   input wire logic command_strobe,
   input wire logic frame_short
);
   // ==========================================
   // Helper state
   logic [5:0] rise_cnt;
   logic sclk_q;
   logic primed;
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         rise_cnt <= 6'h00;
         sclk_q <= 1'b0;
         primed <= 1'b0;
      end else begin
         sclk_q <= sclk;
         if (cs_n) begin
            rise_cnt <= 6'h00;
         end else if (sclk && !sclk_q) begin
            rise_cnt <= rise_cnt + 6'h01;
         end
         // Response path is unknown until one frame has passed
         if (cs_n && rise_cnt == 6'h14) begin
            primed <= 1'b1;
         end
      end
   end
   // ==========================================
   // Properties
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   sclk_idle_a: assert property (cs_n |-> !sclk)
      else $error("bus clock high while deselected");
   lead_time_a: assert property ($fell(cs_n) |-> !sclk [*5])
      else $error("bus clock too soon after select");
   mosi_hold_a: assert property ($rose(sclk) |-> $stable(mosi) [*3])
      else $error("data in moved around clock rise");
   miso_stable_a: assert property (primed && sclk && $past(sclk) |-> $stable(miso))
      else $error("data out moved while clock high");
   strobe_follows_a: assert property (primed && $rose(cs_n) |-> ##[5:10] command_strobe)
      else $error("no command after deselect");
   strobe_cause_a: assert property (command_strobe |-> cs_n && $past(cs_n, 5))
      else $error("command without deselect");
   clock_count_a: assert property ($rose(cs_n) |-> rise_cnt == 6'h14)
      else $error("frame clock count wrong");
   full_frame_a: assert property (command_strobe |-> !frame_short)
      else $error("command flagged as short");
   sclk_high_time_a: assert property ($rose(sclk) |-> sclk [*3])
      else $error("bus clock high phase too short");
   sclk_low_time_a: assert property ($fell(sclk) && !cs_n |-> !sclk [*3])
      else $error("bus clock low phase too short");
endmodule // spi_slave_command_port_properties

// *** tb/spi_slave_command_port_tb_top.sv ***
// Testbench: command port driven by its master over the serial link
`timescale 1ns/100ps
module spi_slave_command_port_tb_top;
   import spi_cmd_pkg::*;
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic start = 1'b0;
   logic start2 = 1'b0;
   logic driver_disable_input = 1'b1;
   logic [9:0] ustep = 10'h000;
   logic [9:0] load = 10'h000;
   logic [4:0] cscale = 5'h00;
   logic [7:0] flags = 8'h00;
   logic [19:0] tx = 20'h00000;
   logic [39:0] tx2 = 40'h0000000000;
   logic busy, done, busy2, done2, command_strobe, frame_short, driver_disable;
   logic [19:0] rx, w_drv, w_chop, w_adapt, w_detect, w_conf, w2_drv;
   logic [39:0] rx2;
   target_t command_target;
   logic [1:0] response_format_select = 2'h0;
   int n_errors = 0;
   int samples_checked = 0;
   spi_link_if link();
   spi_link_if link2();
   // ==========================================
   // Ends of the link
   spi_cmd_master spi_cmd_master_inst (.core_clk, .rst_b, .link(link), .start, .tx_word(tx), .busy, .done,
      .rx_word(rx));
   spi_cmd_port spi_cmd_port_inst (.core_clk, .rst_b, .link(link), .driver_disable_input, .microstep_pos(ustep),
      .load_value(load), .current_scale_act(cscale), .status_flags(flags), .drive_ctrl_word(w_drv),
      .chopper_word(w_chop), .load_adapt_word(w_adapt), .load_detect_word(w_detect),
      .driver_configuration_word(w_conf), .command_strobe, .command_target, .frame_short, .driver_disable);
   // Forty clocks into one port: the first word passes through
   spi_cmd_master #(.CHAIN_LEN(2)) chain_spi_cmd_master_inst (.core_clk, .rst_b, .link(link2),
      .start(start2), .tx_word(tx2), .busy(busy2), .done(done2), .rx_word(rx2));
   spi_cmd_port chain_spi_cmd_port_inst (.core_clk, .rst_b, .link(link2), .driver_disable_input,
      .microstep_pos(ustep), .load_value(load), .current_scale_act(cscale), .status_flags(flags),
      .drive_ctrl_word(w2_drv), .chopper_word(), .load_adapt_word(), .load_detect_word(),
      .driver_configuration_word(), .command_strobe(), .command_target(), .frame_short(), .driver_disable());
   spi_slave_command_port_properties spi_slave_command_port_properties_inst (.core_clk, .rst_b,
      .sclk(link.sclk), .mosi(link.mosi), .miso(link.miso), .cs_n(link.cs_n), .command_strobe, .frame_short);
   initial forever #2 core_clk = ~core_clk;
   // ==========================================
   // Helpers
   function automatic logic [19:0] resp(logic [1:0] f);
      case (f)
         2'h0: return {ustep, 2'h0, flags};
         2'h1: return {load, 10'h000};
         2'h2: return {load[9:5], cscale, 10'h000};
         default: return 20'h00000;
      endcase
   endfunction
   function automatic target_t sel_t(logic [19:0] w);
      return w[19] ? target_t'({1'b0, w[18:17]} + 3'h1) : TGT_DRIVE_CTRL;
   endfunction
   function automatic logic [19:0] word_of(target_t t);
      logic [19:0] ws [5] = '{w_drv, w_chop, w_adapt, w_detect, w_conf};
      return ws[t];
   endfunction
   task automatic check(string nm, logic [19:0] seen, logic [19:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic frame(bit chain);
      int i;
      @(posedge core_clk);
      start <= !chain;
      start2 <= chain;
      @(posedge core_clk);
      start <= 1'b0;
      start2 <= 1'b0;
      @(negedge core_clk);
      check("busy", 20'(chain ? busy2 : busy), 20'h00001);
      for (i = 0; i < 400; i++) begin
         @(negedge core_clk);
         if ((chain ? done2 : done) === 1'b1) break;
      end
      if (i == 400) begin
         n_errors++;
         complete_run();
      end
      check("idle", 20'(chain ? busy2 : busy), 20'h00000);
      repeat (2) @(posedge core_clk);
   endtask
   // ==========================================
   // Sequence
   initial begin
      int k;
      logic [31:0] w;
      logic [63:0] r;
      k = $urandom(32'h2bdf);
      repeat (6) @(posedge core_clk);
      rst_b <= 1'b1;
      repeat (12) @(posedge core_clk);
      frame(0);
      frame(1);
      $display("test prime done");
      for (k = 0; k < 24; k++) begin
         w = $urandom;
         r = {$urandom, $urandom};
         if (k < 8) w[19:17] = k[2:0];
         if (k % 4 == 3) begin
            w[19:17] = 3'h7;
            w[5:4] = k[3:2];
         end
         @(posedge core_clk);
         {ustep, load, cscale, flags} <= r[32:0];
         tx <= w[19:0];
         frame(0);
         check("response", rx, resp(response_format_select));
         check("target", 20'(command_target), 20'(sel_t(w[19:0])));
         check("word", word_of(sel_t(w[19:0])), w[19:0]);
         check("short", 20'(frame_short), 20'h00000);
         if (w[19:17] == 3'h7) response_format_select = w[5:4];
      end
      $display("test random done");
      for (k = 0; k < 4; k++) begin
         r = {$urandom, $urandom};
         r[19] = 1'b0;
         @(posedge core_clk);
         tx2 <= r[39:0];
         frame(1);
         check("chain response", rx2[39:20], resp(2'h0));
         check("chain pass", rx2[19:0], r[39:20]);
         check("chain command", w2_drv, r[19:0]);
      end
      $display("test chain done");
      @(posedge core_clk);
      driver_disable_input <= 1'b0;
      repeat (4) @(negedge core_clk);
      check("disable delay", 20'(driver_disable), 20'h00001);
      repeat (6) @(negedge core_clk);
      check("disable", 20'(driver_disable), 20'h00000);
      @(posedge core_clk);
      driver_disable_input <= 1'b1;
      repeat (3) @(posedge core_clk);
      driver_disable_input <= 1'b0;
      for (k = 0; k < 10; k++) begin
         @(negedge core_clk);
         check("disable glitch", 20'(driver_disable), 20'h00000);
      end
      $display("test filter done");
      complete_run();
   end
endmodule // spi_slave_command_port_tb_top
